//--- design/pwdt_pkg.sv
// Package with register map, field layout, reset values and timing constants of the watchdog.
package pwdt_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int           ADDR_W          = 4;
    localparam logic [3:0]   OFF_CTRL_STATUS = 4'h0;
    localparam logic [3:0]   OFF_COUNTER     = 4'h1;
    localparam logic [3:0]   OFF_CLOCK_MODE  = 4'h2;
    localparam logic [3:0]   OFF_PORT_MODE   = 4'h3;

    // ------------------------------------------------------------------
    // Control/status field positions
    // ------------------------------------------------------------------
    localparam int BIT_CNT_GUARD  = 7;
    localparam int BIT_CNT_WE     = 6;
    localparam int BIT_CTL_GUARD  = 5;
    localparam int BIT_CTL_WE     = 4;
    localparam int BIT_RUN_GUARD  = 3;
    localparam int BIT_RUN        = 2;
    localparam int BIT_FLAG_GUARD = 1;
    localparam int BIT_FLAG       = 0;
    localparam int BIT_CLK_SRC    = 0;
    localparam int BIT_FIELD_TOP  = 3;

    localparam logic [7:0] GUARD_MASK      = 8'haa;
    localparam logic [7:0] CLOCK_MODE_FILL = 8'hf0;
    localparam logic [3:0] CLOCK_MODE_RST  = 4'hf;
    localparam logic [7:0] COUNTER_RST     = 8'h00;
    localparam logic [7:0] COUNTER_TOP     = 8'hff;
    localparam logic [7:0] READ_ZERO       = 8'h00;

    // ------------------------------------------------------------------
    // Clock division
    // ------------------------------------------------------------------
    localparam int         PRESCALE_W     = 13;
    localparam int         SUB_DIV_W      = 5;
    localparam logic [3:0] MIN_DIV_LOG2   = 4'h6;
    localparam logic [3:0] FIXED_DIV_LOG2 = 4'hd;

    // ------------------------------------------------------------------
    // Internal reset length, in oscillator cycles at the core clock rate
    // ------------------------------------------------------------------
    localparam int         RESET_HOLD_OSC_CYCLES = 512;
    localparam int         HOLD_W                = 10;
    localparam logic [9:0] RESET_HOLD_CYCLES     = 10'(RESET_HOLD_OSC_CYCLES);

    // ------------------------------------------------------------------
    // Bus carrier
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pwdt_bus_req_t;

    typedef enum logic [1:0] {
        SRC_SYSTEM = 2'b00,
        SRC_SUB    = 2'b01,
        SRC_OSC    = 2'b10
    } pwdt_src_t;

endpackage : pwdt_pkg

//--- design/pwdt_clk_sel.sv
// Counter clock selector: system clock prescaler, subclock divider and oscillator tick.
`timescale 1ns/10ps
`default_nettype none

module pwdt_clk_sel #(
    parameter bit SECOND_VARIANT = 1'b0
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       resetn,
    // Already synchronised edge events
    input  wire logic       subEdge,
    input  wire logic       oscEdge,
    // Selection
    input  wire logic       clkSrcBit,
    input  wire logic [3:0] clockField,
    // Count enable
    output logic            countTick
);

    logic [12:0] prescale_r;
    logic [4:0]  subDiv_r;
    logic        subTick;
    logic        sysTick;
    logic [3:0]  divLog2;
    pwdt_pkg::pwdt_src_t src;

    // Tick when the low bits of the prescaler are all ones.
    function automatic logic tapTick(input logic [12:0] pre, input logic [3:0] lg);
        logic [12:0] mask;
        mask = 13'((14'h0001 << lg) - 14'h0001);
        return (pre & mask) == mask;
    endfunction : tapTick

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            prescale_r <= '0;
        else
            prescale_r <= prescale_r + 13'h0001;
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            subDiv_r <= '0;
        else if (subEdge)
            subDiv_r <= subDiv_r + 5'h01;
    end

    assign subTick = subEdge && (subDiv_r == 5'h1f);

    always_comb
    begin
        divLog2 = pwdt_pkg::FIXED_DIV_LOG2;
        src     = pwdt_pkg::SRC_SYSTEM;
        if (clkSrcBit)
            src = pwdt_pkg::SRC_SUB;
        else if (SECOND_VARIANT)
        begin
            if (clockField[pwdt_pkg::BIT_FIELD_TOP])
                divLog2 = pwdt_pkg::MIN_DIV_LOG2 + {1'b0, clockField[2:0]};
            else
                src = pwdt_pkg::SRC_OSC;
        end
    end

    assign sysTick = tapTick(prescale_r, divLog2);

    always_comb
    begin
        unique case (src)
            pwdt_pkg::SRC_SYSTEM: countTick = sysTick;
            pwdt_pkg::SRC_SUB:    countTick = subTick;
            pwdt_pkg::SRC_OSC:    countTick = oscEdge;
            default:              countTick = 1'b0;
        endcase
    end

endmodule : pwdt_clk_sel

`default_nettype wire

//--- design/pwdt_top.sv
// Protected watchdog timer: guarded control/status register, counter and internal reset.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Eight-bit counter whose overflow raises an internal chip reset.
// - First variant counts system clock over 8192 or subclock over 32.
// - Second variant: system clock over 64..8192, subclock over 32, or oscillator.
// - Preset counter value gives overflow after 1 to 256 counter clocks.
// - Bits 7, 5, 3 and 1 of control/status always read as one.
// - Counter write enable changes only when bit 7 is written zero.
// - Counter writes take effect only while counter write enable is set.
// - Control write enable changes only when bit 5 is written zero.
// - Run bit and reset flag take writes only while control write enable is set.
// - Run bit loads only with bit 3 written zero and control enable set.
// - Counter advances on selected clock while running, holds otherwise.
// - Reset clears run bit in first variant, sets it in second.
// - Overflow sets the reset flag; external reset clears it.
// - Flag clears on zero written with bit 1 zero and control enable set.
// - Counter is readable, writable, and wraps from all ones raising reset.
// - Counter starts at zero after reset.
// - Second variant forces subclock over 32 when clock source bit is set.
// - Internal reset stays active for 512 core clock cycles.
// - A written counter value is the start point of further counting.
// - Clock field codes 1000..1111 pick divisors 64..8192, 0xxx the oscillator.
// - First variant: source bit zero picks over 8192, one picks subclock.
module pwdt_top #(
    parameter bit SECOND_VARIANT = 1'b0
) (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   resetn,
    // Register port
    input  wire pwdt_pkg::pwdt_bus_req_t busReq,
    output logic [7:0]                  busRdata,
    // Asynchronous clock pins
    input  wire logic                   subClkPin,
    input  wire logic                   oscClkPin,
    // Reset output
    output logic                        internalReset
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic       counterWriteEnable_r;
    logic       controlWriteEnable_r;
    logic       watchdogRun_r;
    logic       watchdogResetFlag_r;
    logic [7:0] wdtCounter_r;
    logic [7:0] wdtCounter_nxt;
    logic [3:0] clockField_r;
    logic       clockSourceBit_r;
    logic [9:0] holdCount_r;
    logic       internalReset_r;
    logic [7:0] busRdata_r;

    logic subSync1_r;
    logic subSync2_r;
    logic subSync3_r;
    logic oscSync1_r;
    logic oscSync2_r;
    logic oscSync3_r;

    logic       subEdge;
    logic       oscEdge;
    logic       countTick;
    logic       overflow;
    logic       csrWrite;
    logic       cntWrite;
    logic       modeWrite;
    logic       portWrite;
    logic [7:0] wd;
    logic [7:0] csrView;

    function automatic logic isWrite(input pwdt_pkg::pwdt_bus_req_t r, input logic [3:0] off);
        return r.wr && (r.addr == off);
    endfunction : isWrite

    assign wd        = busReq.wdata;
    assign csrWrite  = isWrite(busReq, pwdt_pkg::OFF_CTRL_STATUS);
    assign cntWrite  = isWrite(busReq, pwdt_pkg::OFF_COUNTER);
    assign modeWrite = isWrite(busReq, pwdt_pkg::OFF_CLOCK_MODE) && SECOND_VARIANT;
    assign portWrite = isWrite(busReq, pwdt_pkg::OFF_PORT_MODE);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // The third stage only serves edge detection, so the first stage
    // feeds nothing but the second.
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            subSync1_r <= 1'b0;
            subSync2_r <= 1'b0;
            subSync3_r <= 1'b0;
        end
        else
        begin
            subSync1_r <= subClkPin;
            subSync2_r <= subSync1_r;
            subSync3_r <= subSync2_r;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            oscSync1_r <= 1'b0;
            oscSync2_r <= 1'b0;
            oscSync3_r <= 1'b0;
        end
        else
        begin
            oscSync1_r <= oscClkPin;
            oscSync2_r <= oscSync1_r;
            oscSync3_r <= oscSync2_r;
        end
    end

    assign subEdge = subSync2_r && !subSync3_r;
    assign oscEdge = oscSync2_r && !oscSync3_r;

    // ------------------------------------------------------------------
    // Counter clock selection
    // ------------------------------------------------------------------
    pwdt_clk_sel #(
        .SECOND_VARIANT (SECOND_VARIANT)
    ) u_clk_sel (
        .core_clk   (core_clk),
        .resetn     (resetn),
        .subEdge    (subEdge),
        .oscEdge    (oscEdge),
        .clkSrcBit  (clockSourceBit_r),
        .clockField (clockField_r),
        .countTick  (countTick)
    );

    // ------------------------------------------------------------------
    // Guarded control/status bits
    // ------------------------------------------------------------------
    // Software must write this register as a whole byte; a read-modify-write
    // would carry the always-one guard bits back and lock every field.
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            counterWriteEnable_r <= 1'b0;
        else if (csrWrite && !wd[pwdt_pkg::BIT_CNT_GUARD])
            counterWriteEnable_r <= wd[pwdt_pkg::BIT_CNT_WE];
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            controlWriteEnable_r <= 1'b0;
        else if (csrWrite && !wd[pwdt_pkg::BIT_CTL_GUARD])
            controlWriteEnable_r <= wd[pwdt_pkg::BIT_CTL_WE];
    end

    // The enable as it stood before this write governs the run bit and flag,
    // so one write cannot both unlock and change them.
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            watchdogRun_r <= SECOND_VARIANT;
        else if (csrWrite && controlWriteEnable_r && !wd[pwdt_pkg::BIT_RUN_GUARD])
            watchdogRun_r <= wd[pwdt_pkg::BIT_RUN];
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            watchdogResetFlag_r <= 1'b0;
        else if (overflow)
            watchdogResetFlag_r <= 1'b1;
        else if (csrWrite && controlWriteEnable_r
                 && !wd[pwdt_pkg::BIT_FLAG_GUARD] && !wd[pwdt_pkg::BIT_FLAG])
            watchdogResetFlag_r <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Clock mode and port mode
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            clockField_r <= pwdt_pkg::CLOCK_MODE_RST;
        else if (modeWrite)
            clockField_r <= wd[3:0];
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            clockSourceBit_r <= 1'b0;
        else if (portWrite)
            clockSourceBit_r <= wd[pwdt_pkg::BIT_CLK_SRC];
    end

    // ------------------------------------------------------------------
    // Watchdog counter
    // ------------------------------------------------------------------
    // A software write beats a tick in the same cycle; counting resumes from
    // the written value, giving 256 minus preset ticks to overflow.
    assign overflow = watchdogRun_r && countTick && !(cntWrite && counterWriteEnable_r)
                      && (wdtCounter_r == pwdt_pkg::COUNTER_TOP);

    always_comb
    begin
        wdtCounter_nxt = wdtCounter_r;
        if (cntWrite && counterWriteEnable_r)
            wdtCounter_nxt = wd;
        else if (watchdogRun_r && countTick)
            wdtCounter_nxt = wdtCounter_r + 8'h01;
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            wdtCounter_r <= pwdt_pkg::COUNTER_RST;
        else
            wdtCounter_r <= wdtCounter_nxt;
    end

    // ------------------------------------------------------------------
    // Internal reset pulse
    // ------------------------------------------------------------------
    // A fresh overflow while the pulse is active restarts the full length.
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            holdCount_r     <= '0;
            internalReset_r <= 1'b0;
        end
        else if (overflow)
        begin
            holdCount_r     <= pwdt_pkg::RESET_HOLD_CYCLES - 10'h001;
            internalReset_r <= 1'b1;
        end
        else if (holdCount_r != '0)
            holdCount_r <= holdCount_r - 10'h001;
        else
            internalReset_r <= 1'b0;
    end

    assign internalReset = internalReset_r;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb
    begin
        csrView                          = pwdt_pkg::GUARD_MASK;
        csrView[pwdt_pkg::BIT_CNT_WE]    = counterWriteEnable_r;
        csrView[pwdt_pkg::BIT_CTL_WE]    = controlWriteEnable_r;
        csrView[pwdt_pkg::BIT_RUN]       = watchdogRun_r;
        csrView[pwdt_pkg::BIT_FLAG]      = watchdogResetFlag_r;
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            busRdata_r <= pwdt_pkg::READ_ZERO;
        else if (busReq.rd)
        begin
            unique case (busReq.addr)
                pwdt_pkg::OFF_CTRL_STATUS: busRdata_r <= csrView;
                pwdt_pkg::OFF_COUNTER:     busRdata_r <= wdtCounter_r;
                pwdt_pkg::OFF_CLOCK_MODE:  busRdata_r <= SECOND_VARIANT
                                              ? (pwdt_pkg::CLOCK_MODE_FILL | {4'h0, clockField_r})
                                              : pwdt_pkg::READ_ZERO;
                pwdt_pkg::OFF_PORT_MODE:   busRdata_r <= {7'h00, clockSourceBit_r};
                default:                   busRdata_r <= pwdt_pkg::READ_ZERO;
            endcase
        end
        else
            busRdata_r <= pwdt_pkg::READ_ZERO;
    end

    assign busRdata = busRdata_r;

endmodule : pwdt_top

`default_nettype wire

//--- verification/pwdt_props.sv
// Port-level properties of the protected watchdog, bound to every top instance.
`timescale 1ns/10ps
`default_nettype none

module pwdt_props #(
    parameter bit SECOND_VARIANT = 1'b0
) (
    // Clock and reset
    input wire logic                    core_clk,
    input wire logic                    resetn,
    // Register port
    input wire pwdt_pkg::pwdt_bus_req_t busReq,
    input wire logic [7:0]              busRdata,
    // Pins
    input wire logic                    subClkPin,
    input wire logic                    oscClkPin,
    input wire logic                    internalReset
);
    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    logic [9:0] holdCnt_r;
    logic       rdCsr;

    assign rdCsr = busReq.rd && busReq.addr == pwdt_pkg::OFF_CTRL_STATUS;

    always_ff @(posedge core_clk)
    begin
        if (!resetn || !internalReset)
            holdCnt_r <= 10'h000;
        else
            holdCnt_r <= holdCnt_r + 10'h001;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    property p_idle;
        !busReq.rd |=> busRdata == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("read data not zero outside a read");
    property p_guard;
        rdCsr |=> (busRdata & pwdt_pkg::GUARD_MASK) == pwdt_pkg::GUARD_MASK;
    endproperty
    a_guard: assert property (p_guard) else $error("guard bits not read as one");
    property p_unmapped;
        busReq.rd && busReq.addr > pwdt_pkg::OFF_PORT_MODE |=> busRdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_mode_first;
        !SECOND_VARIANT && busReq.rd && busReq.addr == pwdt_pkg::OFF_CLOCK_MODE
            |=> busRdata == 8'h00;
    endproperty
    a_mode_first: assert property (p_mode_first) else $error("mode register seen");
    property p_mode_fill;
        SECOND_VARIANT && busReq.rd && busReq.addr == pwdt_pkg::OFF_CLOCK_MODE
            |=> busRdata[7:4] == 4'hf;
    endproperty
    a_mode_fill: assert property (p_mode_fill) else $error("mode fill not ones");
    property p_hold;
        $fell(internalReset) && $past(resetn) |-> holdCnt_r >= 10'h200;
    endproperty
    a_hold: assert property (p_hold) else $error("internal reset too short");
    property p_flag;
        ($rose(internalReset) && !busReq.wr ##1 rdCsr) |=> busRdata[0];
    endproperty
    a_flag: assert property (p_flag) else $error("flag not set by overflow");
    property p_quiet;
        $rose(resetn) |-> !internalReset && busRdata == 8'h00;
    endproperty
    a_quiet: assert property (p_quiet) else $error("outputs active after reset");
endmodule : pwdt_props

bind pwdt_top pwdt_props #(.SECOND_VARIANT(SECOND_VARIANT)) u_pwdt_props (
    .core_clk(core_clk), .resetn(resetn), .busReq(busReq), .busRdata(busRdata),
    .subClkPin(subClkPin), .oscClkPin(oscClkPin), .internalReset(internalReset));

`default_nettype wire

//--- verification/test_pwdt_top.sv
// Self-checking testbench of the protected watchdog, both variants side by side.
`timescale 1ns/10ps
`default_nettype none

module test_pwdt_top;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic                    core_clk  = 1'b0;
    logic                    resetn    = 1'b0;
    pwdt_pkg::pwdt_bus_req_t busReq    = '0;
    logic                    subClkPin = 1'b0;
    logic                    oscClkPin = 1'b0;
    logic [7:0]              rdata2;
    logic [7:0]              rdata1;
    logic                    intRst2;
    logic                    intRst1;
    logic [7:0]              csrExp, cntExp, seen, seen1, rnd, d;
    logic [9:0]              holdRun   = 10'h000;
    logic [9:0]              lastHold  = 10'h000;
    logic [7:0]              corner [4] = '{8'hff, 8'h7f, 8'hdf, 8'hf7};
    int                      errTotal  = 0;
    int                      checks    = 0;

    always #5 core_clk = ~core_clk;

    pwdt_top #(.SECOND_VARIANT(1'b1)) u_pwdt_top (.core_clk(core_clk), .resetn(resetn),
        .busReq(busReq), .busRdata(rdata2), .subClkPin(subClkPin), .oscClkPin(oscClkPin),
        .internalReset(intRst2));
    pwdt_top #(.SECOND_VARIANT(1'b0)) u_pwdt_top_first (.core_clk(core_clk), .resetn(resetn),
        .busReq(busReq), .busRdata(rdata1), .subClkPin(subClkPin), .oscClkPin(oscClkPin),
        .internalReset(intRst1));

    // Length of the last internal reset pulse, in core clock cycles.
    always @(posedge core_clk)
    begin
        holdRun <= intRst2 ? holdRun + 10'h001 : 10'h000;
        if (!intRst2 && holdRun != 10'h000)
            lastHold <= holdRun;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] lfsr(logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : lfsr

    // Each protected bit is judged alone, against the enables held before the write.
    function automatic logic [7:0] csr_next(logic [7:0] s, logic [7:0] w);
        logic [7:0] n;
        n = s;
        if (!w[7])
            n[6] = w[6];
        if (!w[5])
            n[4] = w[4];
        if (s[4] && !w[3])
            n[2] = w[2];
        if (s[4] && !w[1] && !w[0])
            n[0] = 1'b0;
        return n | pwdt_pkg::GUARD_MASK;
    endfunction : csr_next

    task automatic report_and_stop;
        if (errTotal == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            errTotal++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic bus_write(input logic [3:0] a, input logic [7:0] v);
        @(posedge core_clk);
        busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        busReq <= '0;
        if (a == pwdt_pkg::OFF_CTRL_STATUS)
            csrExp = csr_next(csrExp, v);
    endtask : bus_write

    task automatic bus_read(input logic [3:0] a, output logic [7:0] v2, output logic [7:0] v1);
        @(posedge core_clk);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        busReq <= '0;
        #1;
        v2 = rdata2;
        v1 = rdata1;
    endtask : bus_read

    // Waits for the internal reset to reach a level within a window of cycles.
    task automatic wait_level(input logic lvl, input int lo, input int hi);
        int n;
        n = 0;
        while (intRst2 !== lvl && n < hi)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check("resetEdgeTime", {7'h00, n >= lo && n < hi}, 8'h01);
        if (n >= hi)
            report_and_stop();
    endtask : wait_level

    task automatic pin_pulses(input bit sub, input int n);
        repeat (n)
        begin
            @(posedge core_clk);
            if (sub)
                subClkPin <= 1'b1;
            else
                oscClkPin <= 1'b1;
            repeat (2) @(posedge core_clk);
            subClkPin <= 1'b0;
            oscClkPin <= 1'b0;
            repeat (2) @(posedge core_clk);
        end
        repeat (6) @(posedge core_clk);
    endtask : pin_pulses

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        rnd = 8'h5f;
        cntExp = 8'h00;
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        csrExp = 8'hae;
        bus_read(pwdt_pkg::OFF_CTRL_STATUS, seen, seen1);
        check("csrReset2", seen, 8'hae);
        check("csrReset1", seen1, 8'haa);
        bus_read(pwdt_pkg::OFF_COUNTER, seen, seen1);
        check("cntReset", seen, 8'h00);
        check("cntReset1", seen1, 8'h00);
        bus_read(pwdt_pkg::OFF_CLOCK_MODE, seen, seen1);
        check("modeReset2", seen, 8'hff);
        check("modeReset1", seen1, 8'h00);
        bus_read(4'h9, seen, seen1);
        check("unmapped", seen, 8'h00);
        // Oscillator source with an idle pin freezes the counter for the register tests.
        bus_write(pwdt_pkg::OFF_CLOCK_MODE, 8'h00);
        for (int i = 0; i < 28; i++)
        begin
            rnd = lfsr(rnd);
            d = (i < 4) ? corner[i] : rnd;
            bus_write(pwdt_pkg::OFF_COUNTER, ~d);
            if (csrExp[6])
                cntExp = ~d;
            bus_read(pwdt_pkg::OFF_COUNTER, seen, seen1);
            check("counter", seen, cntExp);
            check("counter1", seen1, cntExp);
            bus_write(pwdt_pkg::OFF_CTRL_STATUS, d);
            bus_read(pwdt_pkg::OFF_CTRL_STATUS, seen, seen1);
            check("csr", seen, csrExp);
        end
        bus_write(pwdt_pkg::OFF_CTRL_STATUS, 8'h5f);
        bus_write(pwdt_pkg::OFF_CTRL_STATUS, 8'hf7);
        bus_write(pwdt_pkg::OFF_COUNTER, 8'hfd);
        pin_pulses(1'b0, 2);
        bus_read(pwdt_pkg::OFF_COUNTER, seen, seen1);
        check("cntRun", seen, 8'hff);
        check("cntRun1", seen1, 8'hfd);
        @(posedge core_clk);
        oscClkPin <= 1'b1;
        wait_level(1'b1, 3, 20);
        csrExp[0] = 1'b1;
        bus_read(pwdt_pkg::OFF_CTRL_STATUS, seen, seen1);
        check("flagSet", seen, csrExp);
        @(posedge core_clk);
        oscClkPin <= 1'b0;
        bus_read(pwdt_pkg::OFF_COUNTER, seen, seen1);
        check("cntWrap", seen, 8'h00);
        wait_level(1'b0, 400, 600);
        // The pulse length is latched at the edge after the fall; look once it has settled.
        @(posedge core_clk);
        #1;
        check("holdLen", lastHold[9:2], 8'h80);
        check("holdLow", {6'h00, lastHold[1:0]}, 8'h00);
        bus_write(pwdt_pkg::OFF_CTRL_STATUS, 8'hfc);
        bus_read(pwdt_pkg::OFF_CTRL_STATUS, seen, seen1);
        check("flagClear", seen, csrExp);
        bus_write(pwdt_pkg::OFF_CTRL_STATUS, 8'hf3);
        bus_write(pwdt_pkg::OFF_COUNTER, 8'hfd);
        pin_pulses(1'b0, 3);
        bus_read(pwdt_pkg::OFF_COUNTER, seen, seen1);
        check("cntStopped", seen, 8'hfd);
        bus_write(pwdt_pkg::OFF_CLOCK_MODE, 8'h08);
        bus_write(pwdt_pkg::OFF_CTRL_STATUS, 8'hf7);
        bus_write(pwdt_pkg::OFF_COUNTER, 8'hfe);
        wait_level(1'b1, 64, 200);
        wait_level(1'b0, 400, 600);
        bus_write(pwdt_pkg::OFF_PORT_MODE, 8'h01);
        bus_write(pwdt_pkg::OFF_COUNTER, 8'hff);
        pin_pulses(1'b1, 31);
        check("subEarly", {7'h00, intRst2}, 8'h00);
        check("subEarly1", {7'h00, intRst1}, 8'h00);
        @(posedge core_clk);
        subClkPin <= 1'b1;
        wait_level(1'b1, 2, 20);
        check("subFirst", {7'h00, intRst1}, 8'h01);
        report_and_stop();
    end
endmodule : test_pwdt_top

`default_nettype wire
